// ---- design/cfg_irq_pkg.sv ----
// constants for the configuration and interrupt-mask block
package cfg_irq_pkg;
    localparam logic [7:0] ADDR_DEVICE_CONFIGURATION    = 8'h06;
    localparam logic [7:0] ADDR_INTERRUPT_EVENT_ENABLE  = 8'h07;
    localparam logic [7:0] RST_DEVICE_CONFIGURATION     = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_EVENT_ENABLE   = 8'h20;
    // configuration fields
    localparam int CFG_SUPPLY_AUTOCLEAR = 7;
    localparam int CFG_SUPPLY_ROUTE     = 6;
    localparam int CFG_OPEN_DISABLE     = 5;
    localparam int CFG_DOT_CORR         = 4;
    localparam int CFG_SHARED_ADDR      = 3;
    localparam int CFG_LAYOUT_HI        = 2;
    localparam int CFG_LAYOUT_LO        = 0;
    localparam logic [2:0] LAYOUT_INVALID = 3'h0;
    localparam logic [2:0] LAYOUT_MAX     = 3'h6;
    localparam logic [6:0] SHARED_I2C_ADDR = 7'h3f;
    // event / mask bit positions
    localparam int EV_FRAME     = 7;
    localparam int EV_WATCHDOG  = 6;
    localparam int EV_POR       = 5;
    localparam int EV_OVERTEMP  = 4;
    localparam int EV_SUPPLY    = 3;
    localparam int EV_OPEN      = 2;
    localparam int EV_SHORT     = 1;
    localparam int EV_MOVIE_FIN = 0;
    localparam int NUM_EVENTS   = 8;
endpackage

// ---- design/led_driver_config_irq_mask.sv ----
// configuration register and interrupt event mask of the led matrix driver
module led_driver_config_irq_mask
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       led_data_wr,
    input  wire logic       supply_low_det,
    input  wire logic       display_end,
    input  wire logic       frame_hit,
    input  wire logic       watchdog_fire,
    input  wire logic       por_active,
    input  wire logic       overtemp,
    input  wire logic       open_err,
    input  wire logic       short_err,
    input  wire logic       movie_fin,
    input  wire logic [6:0] i2c_match_addr,
    output logic            shared_addr_hit,
    output logic            open_led_disable,
    output logic            dot_corr_en,
    output logic      [2:0] ram_layout,
    output logic            layout_valid,
    output logic            locked,
    output logic            supply_low_flag,
    output logic      [7:0] event_status,
    output logic            irq
);
    import cfg_irq_pkg::*;

    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;
    logic [7:0] mask_ff;
    logic       lock_ff;
    logic       nxt_lock;
    logic       supply_ff;
    logic       nxt_supply;
    logic [7:0] status_ff;
    logic       irq_ff;
    logic       nxt_irq;
    logic       hit_ff;
    logic       nxt_hit;
    logic       valid_ff;
    logic       nxt_valid;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       cfg_wr;
    logic       mask_wr;
    logic [7:0] ev;
    logic [7:0] ev_masked;

    // ==========================================================
    // register write decode
    always_comb
    begin
        cfg_wr  = reg_wr && (reg_addr == ADDR_DEVICE_CONFIGURATION);
        mask_wr = reg_wr && (reg_addr == ADDR_INTERRUPT_EVENT_ENABLE);
    end

    // ==========================================================
    // configuration register
    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (cfg_wr)
        begin
            nxt_cfg[CFG_SUPPLY_AUTOCLEAR] = reg_wdata[CFG_SUPPLY_AUTOCLEAR];
            nxt_cfg[CFG_SUPPLY_ROUTE]     = reg_wdata[CFG_SUPPLY_ROUTE];
            nxt_cfg[CFG_OPEN_DISABLE]     = reg_wdata[CFG_OPEN_DISABLE];
            nxt_cfg[CFG_SHARED_ADDR]      = reg_wdata[CFG_SHARED_ADDR];
            if (!lock_ff)
            begin
                nxt_cfg[CFG_DOT_CORR]                = reg_wdata[CFG_DOT_CORR];
                nxt_cfg[CFG_LAYOUT_HI:CFG_LAYOUT_LO] = reg_wdata[CFG_LAYOUT_HI:CFG_LAYOUT_LO];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            cfg_ff <= RST_DEVICE_CONFIGURATION;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
        end
    end

    // layout decode registered so the valid pin comes from a flop
    always_comb
    begin
        nxt_valid = (nxt_cfg[CFG_LAYOUT_HI:CFG_LAYOUT_LO] != LAYOUT_INVALID) &&
                    (nxt_cfg[CFG_LAYOUT_HI:CFG_LAYOUT_LO] <= LAYOUT_MAX);
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            valid_ff <= 1'b0;
        end
        else
        begin
            valid_ff <= nxt_valid;
        end
    end

    // ==========================================================
    // write lock, released only by reset
    always_comb
    begin
        nxt_lock = lock_ff;
        if (led_data_wr)
        begin
            nxt_lock = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            lock_ff <= 1'b0;
        end
        else
        begin
            lock_ff <= nxt_lock;
        end
    end

    // ==========================================================
    // interrupt mask register
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            mask_ff <= RST_INTERRUPT_EVENT_ENABLE;
        end
        else if (mask_wr)
        begin
            mask_ff <= reg_wdata;
        end
    end

    // ==========================================================
    // supply-low flag: detection wins over autoclear
    always_comb
    begin
        nxt_supply = supply_ff;
        if (display_end && cfg_ff[CFG_SUPPLY_AUTOCLEAR])
        begin
            nxt_supply = 1'b0;
        end
        if (supply_low_det)
        begin
            nxt_supply = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            supply_ff <= 1'b0;
        end
        else
        begin
            supply_ff <= nxt_supply;
        end
    end

    // ==========================================================
    // event vector, status and irq pin
    always_comb
    begin
        ev               = '0;
        ev[EV_FRAME]     = frame_hit;
        ev[EV_WATCHDOG]  = watchdog_fire;
        ev[EV_POR]       = por_active;
        ev[EV_OVERTEMP]  = overtemp;
        ev[EV_SUPPLY]    = supply_ff;
        ev[EV_OPEN]      = open_err;
        ev[EV_SHORT]     = short_err;
        ev[EV_MOVIE_FIN] = movie_fin;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            status_ff <= '0;
        end
        else
        begin
            status_ff <= ev;
        end
    end

    for (genvar idx = 0; idx < NUM_EVENTS; idx++)
    begin : g_event_gate
        assign ev_masked[idx] = ev[idx] & mask_ff[idx];
    end

    always_comb
    begin
        if (cfg_ff[CFG_SUPPLY_ROUTE])
        begin
            nxt_irq = supply_ff;
        end
        else
        begin
            nxt_irq = |ev_masked;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= nxt_irq;
        end
    end

    // ==========================================================
    // shared i2c address match
    always_comb
    begin
        nxt_hit = cfg_ff[CFG_SHARED_ADDR] && (i2c_match_addr == SHARED_I2C_ADDR);
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            hit_ff <= 1'b0;
        end
        else
        begin
            hit_ff <= nxt_hit;
        end
    end

    // ==========================================================
    // register read port
    always_comb
    begin
        nxt_rdata = '0;
        if (reg_addr == ADDR_DEVICE_CONFIGURATION)
        begin
            nxt_rdata = cfg_ff;
        end
        else if (reg_addr == ADDR_INTERRUPT_EVENT_ENABLE)
        begin
            nxt_rdata = mask_ff;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // output pins
    assign reg_rdata        = rdata_ff;
    assign shared_addr_hit  = hit_ff;
    assign open_led_disable = cfg_ff[CFG_OPEN_DISABLE];
    assign dot_corr_en      = cfg_ff[CFG_DOT_CORR];
    assign ram_layout       = cfg_ff[CFG_LAYOUT_HI:CFG_LAYOUT_LO];
    assign layout_valid     = valid_ff;
    assign locked           = lock_ff;
    assign supply_low_flag  = supply_ff;
    assign event_status     = status_ff;
    assign irq              = irq_ff;
endmodule

// ---- testbench/evt_far.sv ----
// far-side model driving event lines
module evt_far
(
    input  wire logic       clock,
    input  wire logic [7:0] want,
    output logic      [7:0] ev
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(negedge clock) ev <= want;
endmodule

// ---- testbench/cfg_irq_props.sv ----
// assertion checker for the config block
module cfg_irq_props
(
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       led_data_wr,
    input wire logic       supply_low_det,
    input wire logic       display_end,
    input wire logic [6:0] i2c_match_addr,
    input wire logic       shared_addr_hit,
    input wire logic       dot_corr_en,
    input wire logic [2:0] ram_layout,
    input wire logic       layout_valid,
    input wire logic       locked,
    input wire logic       supply_low_flag,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cfg_ff;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // shadow config register
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            cfg_ff <= 8'h00;
        else if (reg_wr && reg_addr == 8'h06)
            cfg_ff <= locked ? {reg_wdata[7:5], cfg_ff[4], reg_wdata[3], cfg_ff[2:0]} : reg_wdata;
    end
    sequence route_steady;
        cfg_ff[6] && $stable(supply_low_flag);
    endsequence
    a_flag_set: assert property (supply_low_det |=> supply_low_flag) else $error("flag set");
    a_flag_clear: assert property (cfg_ff[7] && display_end && !supply_low_det |=> !supply_low_flag)
        else $error("flag clear");
    a_flag_keep: assert property (!cfg_ff[7] && supply_low_flag |=> supply_low_flag) else $error("flag keep");
    a_route_flag: assert property (route_steady ##1 route_steady |-> irq == supply_low_flag)
        else $error("route");
    a_lock_hold: assert property (led_data_wr || locked |=> locked) else $error("lock hold");
    a_lock_refuse: assert property (locked |=> $stable(dot_corr_en) && $stable(ram_layout))
        else $error("lock");
    a_shared_hit: assert property (cfg_ff[3] && i2c_match_addr == 7'h3f |=> shared_addr_hit)
        else $error("hit");
    a_shared_miss: assert property (!cfg_ff[3] || i2c_match_addr != 7'h3f |=> !shared_addr_hit)
        else $error("miss");
    a_layout_field: assert property (ram_layout == cfg_ff[2:0] && layout_valid == (cfg_ff[2:0] inside {[1:6]}))
        else $error("layout");
endmodule
bind led_driver_config_irq_mask cfg_irq_props chk (.clock, .reset_n, .reg_wr, .reg_addr, .reg_wdata,
    .led_data_wr, .supply_low_det, .display_end, .i2c_match_addr, .shared_addr_hit, .dot_corr_en,
    .ram_layout, .layout_valid, .locked, .supply_low_flag, .irq);

// ---- testbench/tb_top.sv ----
// self-checking bench for the config block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock, reset_n, reg_wr, led_data_wr, display_end, hit, opn, dot, valid, locked, flag, irq;
    logic [7:0] reg_addr, reg_wdata, rdata, want, ev, stat;
    logic [6:0] addr7;
    logic [2:0] lay;
    int         bad_count, checks;
    led_driver_config_irq_mask dut (.clock, .reset_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata(rdata),
        .led_data_wr, .display_end, .frame_hit(ev[7]), .watchdog_fire(ev[6]), .por_active(ev[5]),
        .overtemp(ev[4]), .supply_low_det(ev[3]), .open_err(ev[2]), .short_err(ev[1]), .movie_fin(ev[0]),
        .i2c_match_addr(addr7), .shared_addr_hit(hit), .open_led_disable(opn), .dot_corr_en(dot),
        .ram_layout(lay), .layout_valid(valid), .locked, .supply_low_flag(flag), .event_status(stat), .irq);
    evt_far far (.clock, .want, .ev);
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        tick(2);
        chk("rdata", e, rdata);
    endtask
    task automatic pulse_end;
        display_end <= 1'b1;
        tick(1);
        display_end <= 1'b0;
        tick(2);
    endtask
    task automatic close_out;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial
    begin
        #2000000;
        bad_count++;
        close_out;
    end
    initial
    begin
        {reset_n, reg_wr, led_data_wr, display_end, reg_addr, reg_wdata, want, addr7} = '0;
        tick(16);
        reset_n <= 1'b1;
        rd(8'h06, 8'h00);
        rd(8'h07, 8'h20);
        rd(8'h08, 8'h00);
        want <= 8'h20;
        tick(3);
        chk("irq", 8'h1, 8'(irq));
        for (int i = 0; i < 8; i++)
        begin
            if (i != 3)
            begin
                want <= ~(8'h01 << i) & 8'hf7;
                wr(8'h07, 8'h01 << i);
                tick(2);
                chk("irq", 8'h0, 8'(irq));
                want <= 8'h01 << i;
                tick(3);
                chk("irq", 8'h1, 8'(irq));
                chk("stat", 8'h01 << i, stat);
            end
        end
        wr(8'h07, 8'h08);
        want <= 8'h08;
        tick(3);
        chk("stat", 8'h1, 8'(stat[3]));
        want <= 8'h00;
        pulse_end;
        chk("flag", 8'h1, 8'(flag));
        chk("irq", 8'h1, 8'(irq));
        wr(8'h06, 8'h80);
        pulse_end;
        chk("irq", 8'h0, 8'(irq));
        chk("flag", 8'h0, 8'(flag));
        wr(8'h06, 8'hc0);
        wr(8'h07, 8'h20);
        want <= 8'h08;
        tick(1);
        want <= 8'h00;
        tick(3);
        chk("irq", 8'h1, 8'(irq));
        chk("stat", 8'h08, stat);
        want <= 8'h20;
        pulse_end;
        chk("irq", 8'h0, 8'(irq));
        chk("stat", 8'h20, stat);
        wr(8'h06, 8'h3b);
        addr7 <= 7'h3f;
        tick(2);
        chk("cfg", 8'h7b, {1'b0, hit, opn, dot, valid, lay});
        wr(8'h06, 8'h17);
        chk("cfg", 8'h17, {1'b0, hit, opn, dot, valid, lay});
        wr(8'h06, 8'h15);
        led_data_wr <= 1'b1;
        tick(1);
        led_data_wr <= 1'b0;
        wr(8'h06, 8'h22);
        rd(8'h06, 8'h35);
        wr(8'h07, 8'h41);
        rd(8'h07, 8'h41);
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        wr(8'h06, 8'h02);
        chk("locked", 8'h0, 8'(locked));
        rd(8'h06, 8'h02);
        rd(8'h07, 8'h20);
        close_out;
    end
endmodule
